// >>> hw/dcf_defines.svh
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH
`define DCF_OFF_STATUS     8'h00
`define DCF_OFF_EMPTY_OFS  8'h04
`define DCF_OFF_FULL_OFS   8'h08
`define DCF_OFF_LEVEL      8'h0C
`define DCF_DEF_OFS_PAR    16'h007F
`define DCF_DEF_OFS_SER    16'h03FF
`define DCF_STS_MODE_BIT   8
`define DCF_STS_SERIAL_BIT 9
`endif

// >>> hw/dcf_pkg.sv
package dcf_pkg;
	// pins that cross from the outside world, sampled together
	typedef struct packed {
		logic       write_clk;
		logic       read_clk;
		logic       write_enable_n;
		logic       read_enable_n;
		logic       offset_load_n;
		logic       serial_enable_n;
		logic       replay_request_n;
		logic       master_reset_n;
		logic       partial_reset_n;
		logic       fall_through_select_serial_in;
		logic [8:0] write_data;
	} dcf_pins_t;

	// flag pins as seen outside, active levels per pin
	typedef struct packed {
		logic empty_flag_n;     // output_ready_n in fall-through
		logic full_flag_n;      // input_ready_n in fall-through
		logic almost_empty_n;
		logic almost_full_n;
		logic half_full_n;
	} dcf_flags_t;
endpackage : dcf_pkg

// >>> hw/dcf_fifo_ctrl.sv
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dcf_defines.svh"
module dcf_fifo_ctrl #(
	parameter int DEPTH = 65536,
	parameter int OW    = 16
) (
	input  wire logic               clk_sys_i,
	input  wire logic               rst_i,
	input  wire dcf_pkg::dcf_pins_t pins_i,
	output logic [8:0]              read_data_o,
	output dcf_pkg::dcf_flags_t     flags_o,
	input  wire logic               psel_i,
	input  wire logic               penable_i,
	input  wire logic               pwrite_i,
	input  wire logic [7:0]         paddr_i,
	input  wire logic [31:0]        pwdata_i,
	output logic [31:0]             prdata_o,
	output logic                    pready_o,
	output logic                    pslverr_o
);
	import dcf_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
	localparam logic [AW:0] HALF_C  = (AW+1)'(DEPTH / 2);

	generate
		if ((DEPTH != (1 << AW)) || (DEPTH < 4) || (OW < 10) || (OW > AW))
		begin : g_bad
			$error("dcf_fifo_ctrl: DEPTH must be a power of two, 10 <= OW <= log2(DEPTH)");
		end
	endgenerate

	dcf_pins_t  s1_r;
	dcf_pins_t  s2_r;
	logic       wclk_d_r;
	logic       rclk_d_r;
	logic       wtick;
	logic       rtick;
	logic       mrs_act;
	logic       prs_act;
	logic       clr;
	logic       mode_ft_r;
	logic       serial_r;
	logic [OW-1:0] eofs_r;
	logic [OW-1:0] fofs_r;
	logic [8:0] mem [DEPTH];
	logic [AW:0] wptr_r;
	logic [AW:0] rptr_r;
	logic [AW:0] rq1_r;
	logic [AW:0] rq2_r;
	logic [AW:0] wq1_r;
	logic [AW:0] wq2_r;
	logic       full_r;
	logic       afull_n_r;
	logic       aempty_n_r;
	logic       hf_n_r;
	logic       ef_n_r;
	logic       ov_r;
	logic [8:0] dout_r;
	logic [AW:0] wptr_nxt;
	logic [AW:0] rptr_nxt;
	logic [AW:0] wcnt_nxt;
	logic [AW:0] rcnt_nxt;
	logic       do_write;
	logic       do_load;
	logic       rd_empty;

	function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
		bin2gray = b ^ (b >> 1);
	endfunction : bin2gray

	function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
		logic [AW:0] b;
		b = '0;
		for (int i = AW; i >= 0; i--)
		begin
			b[i] = g[i] ^ ((i == AW) ? 1'b0 : b[i+1]);
		end
		gray2bin = b;
	endfunction : gray2bin

	// two-stage sampling of every pin; only stage two is read
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			s1_r <= '1;
			s2_r <= '1;
		end
		else
		begin
			s1_r <= pins_i;
			s2_r <= s1_r;
		end
	end

	// edge finders for the two pin clocks
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			wclk_d_r <= 1'b1;
			rclk_d_r <= 1'b1;
		end
		else
		begin
			wclk_d_r <= s2_r.write_clk;
			rclk_d_r <= s2_r.read_clk;
		end
	end

	// each side ticks on its own edges; a shared clock ticks both
	assign wtick   = s2_r.write_clk & ~wclk_d_r;
	assign rtick   = s2_r.read_clk & ~rclk_d_r;
	assign mrs_act = ~s2_r.master_reset_n;
	assign prs_act = ~s2_r.partial_reset_n;
	assign clr     = mrs_act | prs_act;

	// mode and method are caught only while master reset is held
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			mode_ft_r <= 1'b0;
			serial_r  <= 1'b0;
		end
		else if (mrs_act)
		begin
			// select pin picks the timing mode
			mode_ft_r <= s2_r.fall_through_select_serial_in;
			serial_r  <= s2_r.offset_load_n;
		end
	end

	// offset registers: defaults, serial shift, bus writes
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			eofs_r <= OW'(`DCF_DEF_OFS_PAR);
			fofs_r <= OW'(`DCF_DEF_OFS_PAR);
		end
		else if (mrs_act)
		begin
			// default threshold follows the load pin
			eofs_r <= s2_r.offset_load_n ? OW'(`DCF_DEF_OFS_SER) : OW'(`DCF_DEF_OFS_PAR);
			fofs_r <= s2_r.offset_load_n ? OW'(`DCF_DEF_OFS_SER) : OW'(`DCF_DEF_OFS_PAR);
		end
		// select pin shifts offsets in, empty offset first
		else if (wtick && serial_r && !s2_r.offset_load_n && !s2_r.serial_enable_n)
		begin
			eofs_r <= {eofs_r[OW-2:0], fofs_r[OW-1]};
			fofs_r <= {fofs_r[OW-2:0], s2_r.fall_through_select_serial_in};
		end
		// parallel writes only when parallel method chosen
		else if (psel_i && penable_i && pready_o && pwrite_i && !serial_r)
		begin
			if (paddr_i == `DCF_OFF_EMPTY_OFS)
				eofs_r <= pwdata_i[OW-1:0];
			if (paddr_i == `DCF_OFF_FULL_OFS)
				fofs_r <= pwdata_i[OW-1:0];
		end
	end

	// write side next values
	always_comb
	begin
		do_write = wtick && !s2_r.write_enable_n && s2_r.offset_load_n && !full_r;
		wptr_nxt = wptr_r + (AW+1)'(do_write);
		wcnt_nxt = wptr_nxt - gray2bin(rq2_r);
	end

	// one word per write edge; full refuses it
	always_ff @(posedge clk_sys_i)
	begin
		if (do_write && !rst_i && !clr)
			mem[wptr_r[AW-1:0]] <= s2_r.write_data;
	end

	// write pointer, read pointer view, full and almost full
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || clr)
		begin
			wptr_r    <= '0;
			rq1_r     <= '0;
			rq2_r     <= '0;
			full_r    <= 1'b0;
			afull_n_r <= 1'b1;
		end
		// nothing here moves without a write edge
		else if (wtick)
		begin
			wptr_r <= wptr_nxt;
			// gray read pointer through two write-edge stages
			rq1_r  <= bin2gray(rptr_r);
			rq2_r  <= rq1_r;
			// memory count only, output word extra
			full_r    <= (wcnt_nxt == DEPTH_C);
			afull_n_r <= !(wcnt_nxt >= (DEPTH_C - (AW+1)'(fofs_r)));
		end
	end

	// read side next values
	always_comb
	begin
		rd_empty = (bin2gray(rptr_r) == wq2_r);
		do_load  = 1'b0;
		if (rtick && s2_r.replay_request_n && s2_r.offset_load_n && !rd_empty)
		begin
			if (mode_ft_r)
				do_load = !ov_r || !s2_r.read_enable_n;
			else
				do_load = ef_n_r && !s2_r.read_enable_n;
		end
		rptr_nxt = rptr_r + (AW+1)'(do_load);
		rcnt_nxt = gray2bin(wq2_r) - rptr_nxt;
	end

	// read pointer, output register, empty and output ready
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || clr)
		begin
			// output register zeroed by either reset
			rptr_r     <= '0;
			wq1_r      <= '0;
			wq2_r      <= '0;
			dout_r     <= '0;
			ov_r       <= 1'b0;
			ef_n_r     <= 1'b0;
			aempty_n_r <= 1'b0;
		end
		// nothing here moves without a read edge
		else if (rtick)
		begin
			// gray write pointer through two read-edge stages
			wq1_r <= bin2gray(wptr_r);
			wq2_r <= wq1_r;
			aempty_n_r <= !(rcnt_nxt <= (AW+1)'(eofs_r));
			// replay request restarts reading from location zero
			if (!s2_r.replay_request_n)
			begin
				rptr_r <= '0;
				// empty low, output ready high during setup
				ef_n_r <= 1'b0;
				ov_r   <= 1'b0;
			end
			else
			begin
				rptr_r <= rptr_nxt;
				// load on request, or fall through when idle
				if (do_load)
					dout_r <= mem[rptr_r[AW-1:0]];
				if (mode_ft_r)
				begin
					// true read of the last word drops valid
					if (do_load)
						ov_r <= 1'b1;
					else if (!s2_r.read_enable_n && s2_r.offset_load_n)
						ov_r <= 1'b0;
				end
				ef_n_r <= (bin2gray(rptr_nxt) != wq2_r);
			end
		end
	end

	// half full: write edges only lower it, read edges only raise it
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || clr)
			hf_n_r <= 1'b1;
		// write edges can only drive half full low
		else if (wtick && (wcnt_nxt > HALF_C))
			hf_n_r <= 1'b0;
		// read edges can only drive half full high
		else if (rtick && (rcnt_nxt <= HALF_C))
			hf_n_r <= 1'b1;
	end

	// pin registers; the dual pins change sense with the mode
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			flags_o     <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
			read_data_o <= '0;
		end
		else
		begin
			// dual pins keep the mode across partial reset
			flags_o.empty_flag_n   <= mode_ft_r ? !ov_r : ef_n_r;
			flags_o.full_flag_n    <= mode_ft_r ? full_r : !full_r;
			flags_o.almost_empty_n <= aempty_n_r;
			flags_o.almost_full_n  <= afull_n_r;
			flags_o.half_full_n    <= hf_n_r;
			read_data_o            <= dout_r;
		end
	end

	// bus slave: answers one cycle into the access phase
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= '0;
		end
		else
		begin
			pready_o  <= psel_i && penable_i && !pready_o;
			pslverr_o <= 1'b0;
			prdata_o  <= '0;
			if (psel_i && penable_i && !pready_o)
			begin
				unique case (paddr_i)
					`DCF_OFF_STATUS:
						prdata_o <= {22'h0, serial_r, mode_ft_r, 3'h0, flags_o};
					// offsets read back whatever the method
					`DCF_OFF_EMPTY_OFS: prdata_o <= 32'(eofs_r);
					`DCF_OFF_FULL_OFS:  prdata_o <= 32'(fofs_r);
					`DCF_OFF_LEVEL:     prdata_o <= 32'(gray2bin(wq2_r) - rptr_r);
					default:            pslverr_o <= 1'b1;
				endcase
			end
		end
	end

	sequence s_replay;
		rtick && !s2_r.replay_request_n && !clr;
	endsequence

	sequence s_full_write;
		wtick && full_r && !s2_r.write_enable_n && !clr;
	endsequence

	AST_MRS_PTRS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		mrs_act |=> (wptr_r == '0) && (rptr_r == '0) && !aempty_n_r && afull_n_r && hf_n_r)
		else $error("master reset left pointers or flags");
	AST_MRS_STD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		mrs_act && !s2_r.fall_through_select_serial_in ##1 mrs_act |=> !mode_ft_r
			&& !flags_o.empty_flag_n && flags_o.full_flag_n)
		else $error("standard mode flags wrong after master reset");
	AST_MRS_FT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		mrs_act && s2_r.fall_through_select_serial_in ##1 mrs_act |=> mode_ft_r
			&& flags_o.empty_flag_n && !flags_o.full_flag_n)
		else $error("fall-through flags wrong after master reset");
	AST_DEF_OFS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		mrs_act |=> (eofs_r == (serial_r ? OW'(`DCF_DEF_OFS_SER) : OW'(`DCF_DEF_OFS_PAR))) && (fofs_r == eofs_r))
		else $error("default offsets wrong");
	AST_ZERO_OUT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		clr |=> ##1 (read_data_o == '0))
		else $error("output register not cleared by reset");
	AST_PRS_KEEP: assert property (@(posedge clk_sys_i) disable iff (rst_i || mrs_act)
		prs_act && !(psel_i && penable_i) |=> $stable(eofs_r) && $stable(fofs_r) && $stable(mode_ft_r) && $stable(serial_r))
		else $error("partial reset changed settings");
	AST_RT_PTR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_replay |=> (rptr_r == '0) && !ef_n_r && !ov_r)
		else $error("replay did not restart read pointer");
	AST_NO_OVF: assert property (@(posedge clk_sys_i) disable iff (rst_i || clr)
		s_full_write |=> $stable(wptr_r))
		else $error("write taken while full");
	AST_STD_REQ: assert property (@(posedge clk_sys_i) disable iff (rst_i || clr)
		!mode_ft_r && (rptr_r != $past(rptr_r)) |-> $past(rtick && !s2_r.read_enable_n) || (rptr_r == '0))
		else $error("standard mode read without request");
endmodule : dcf_fifo_ctrl
`default_nettype wire

// >>> tb/dcf_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// writer and reader on their own 64 ns pin clocks, unrelated to the system clock
module dcf_far_end (
	output logic       write_clk_o,
	output logic       read_clk_o,
	output logic       write_enable_n_o,
	output logic       read_enable_n_o,
	output logic       replay_request_n_o,
	output logic [8:0] write_data_o
);
	event rd_evt;

	// offset read clock so the two never line up
	initial
	begin
		write_clk_o = 1'b0;
		forever #32 write_clk_o = ~write_clk_o;
	end
	initial
	begin
		read_clk_o = 1'b0;
		#13;
		forever #32 read_clk_o = ~read_clk_o;
	end
	initial
	begin
		write_enable_n_o   = 1'b1;
		read_enable_n_o    = 1'b1;
		replay_request_n_o = 1'b1;
		write_data_o       = 9'h000;
	end

	// one word per write edge, enable held low across a burst
	task automatic wr(input logic [8:0] d, input bit last);
		@(negedge write_clk_o);
		write_enable_n_o <= 1'b0;
		write_data_o     <= d;
		if (last)
		begin
			@(negedge write_clk_o);
			write_enable_n_o <= 1'b1;
			write_data_o     <= ~d; // released bus shows no stale word
		end
	endtask : wr

	task automatic rd(input int n);
		@(negedge read_clk_o);
		read_enable_n_o <= 1'b0;
		repeat (n)
		begin
			@(posedge read_clk_o);
			-> rd_evt;
		end
		@(negedge read_clk_o);
		read_enable_n_o <= 1'b1;
	endtask : rd

	task automatic replay();
		@(negedge read_clk_o);
		replay_request_n_o <= 1'b0;
		@(negedge read_clk_o);
		replay_request_n_o <= 1'b1;
	endtask : replay
endmodule : dcf_far_end
`default_nettype wire

// >>> tb/dcf_fifo_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_ctrl_bench;
	import dcf_pkg::*;
	// smallest depth whose offset width still holds the 1023 default
	localparam int DEPTH = 1024;
	localparam int OW    = 10;
	logic        clk_sys_i, rst_i, psel, penable, pwrite, mrst_n, prst_n, ld_n, sel_si, err;
	logic        wclk, rclk, wen_n, ren_n, rt_n, sen_n, pready_o, pslverr_o;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata_o, rd, seed;
	logic [8:0]  read_data_o, wd, wdat;
	dcf_flags_t  flags_o;
	dcf_pins_t   pins;
	int          failures, tests_run, cyc;
	logic [8:0]  exp_q[$], keep_q[$];

	// serial enable only drops while offsets are shifted in
	assign pins = {wclk, rclk, wen_n, ren_n, ld_n, sen_n, rt_n, mrst_n, prst_n, sel_si, wdat};

	dcf_fifo_ctrl #(.DEPTH(DEPTH), .OW(OW)) u_dcf_fifo_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .pins_i(pins),
		.read_data_o(read_data_o), .flags_o(flags_o), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
	dcf_far_end u_dcf_far_end (.write_clk_o(wclk), .read_clk_o(rclk), .write_enable_n_o(wen_n),
		.read_enable_n_o(ren_n), .replay_request_n_o(rt_n), .write_data_o(wdat));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	// hang guard, about twice the eighteen thousand cycles the run needs
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			failures++;
			end_of_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	// one APB transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		do
			@(posedge clk_sys_i);
		while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic settle();
		repeat (40) @(posedge clk_sys_i);
	endtask : settle

	// write n random words, noting the first k as expected reads
	task automatic put(input int n, input int k);
		for (int i = 0; i < n; i++)
		begin
			seed = xs(seed);
			wd = seed[8:0];
			if (i < k)
			begin
				exp_q.push_back(wd);
				keep_q.push_back(wd);
			end
			u_dcf_far_end.wr(wd, i == n - 1);
		end
		settle();
	endtask : put

	// reset held for five write clock periods; straps sampled meanwhile
	task automatic rst_pin(input bit master, input logic s, input logic l);
		@(posedge clk_sys_i);
		if (master)
			mrst_n <= 1'b0;
		else
			prst_n <= 1'b0;
		sel_si <= s;
		ld_n   <= l;
		repeat (40) @(posedge clk_sys_i);
		mrst_n <= 1'b1;
		prst_n <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		sel_si <= 1'b0;
		ld_n   <= 1'b1;
		settle();
	endtask : rst_pin

	// offsets on the select pin, one bit per write edge, empty offset first
	task automatic ser_load(input logic [2*OW-1:0] v);
		for (int i = 2 * OW - 1; i >= 0; i--)
		begin
			@(negedge wclk);
			@(posedge clk_sys_i);
			ld_n   <= 1'b0;
			sen_n  <= 1'b0;
			sel_si <= v[i];
		end
		// raised half a write period before the next edge: no extra shift
		@(negedge wclk);
		@(posedge clk_sys_i);
		ld_n   <= 1'b1;
		sen_n  <= 1'b1;
		sel_si <= 1'b0;
		settle();
	endtask : ser_load

	// each read edge's word against the oldest note
	initial
	forever
	begin
		@(u_dcf_far_end.rd_evt);
		repeat (6) @(posedge clk_sys_i);
		if (exp_q.size() == 0)
			chk("spare read", 32'h0, 32'h1);
		else
			chk("read_data", {23'h0, exp_q.pop_front()}, {23'h0, read_data_o});
	end

	initial
	begin
		{rst_i, mrst_n, prst_n, ld_n, sen_n} = 5'h1F;
		{psel, penable, pwrite, sel_si} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		seed = 32'd85760;
		{failures, tests_run, cyc} = '0;
		repeat (5) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rst_pin(1'b1, 1'b0, 1'b0);
		chk("flags", 32'h0B, flags_o);
		chk("read_data", 32'h0, read_data_o);
		apb(1'b0, 8'h00, 32'h0);
		chk("method", 32'h0, rd & 32'h300);
		apb(1'b0, 8'h08, 32'h0);
		chk("full ofs", 32'h7F, rd[15:0]);
		apb(1'b1, 8'h04, 32'h55);
		apb(1'b0, 8'h04, 32'h0);
		chk("empty ofs", 32'h55, rd[15:0]);
		apb(1'b0, 8'h40, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		$display("test defaults done");
		put(3, 3);
		chk("empty_n", 32'h1, flags_o.empty_flag_n);
		u_dcf_far_end.rd(3);
		settle();
		chk("empty_n", 32'h0, flags_o.empty_flag_n);
		$display("test standard done");
		put(DEPTH + 1, DEPTH);
		chk("full_n", 32'h0, flags_o.full_flag_n);
		chk("half_n", 32'h0, flags_o.half_full_n);
		chk("afull_n", 32'h0, flags_o.almost_full_n);
		chk("aempty_n", 32'h1, flags_o.almost_empty_n);
		u_dcf_far_end.rd(1);
		settle();
		chk("full_n", 32'h1, flags_o.full_flag_n);
		u_dcf_far_end.rd(DEPTH - 1);
		settle();
		chk("half_n", 32'h1, flags_o.half_full_n);
		chk("aempty_n", 32'h0, flags_o.almost_empty_n);
		$display("test fill done");
		rst_pin(1'b0, 1'b0, 1'b1);
		chk("flags", 32'h0B, flags_o);
		apb(1'b0, 8'h04, 32'h0);
		chk("kept ofs", 32'h55, rd[15:0]);
		keep_q.delete();
		put(2, 2);
		u_dcf_far_end.rd(2);
		settle();
		u_dcf_far_end.replay();
		settle();
		chk("empty_n", 32'h1, flags_o.empty_flag_n);
		exp_q = keep_q;
		u_dcf_far_end.rd(2);
		settle();
		$display("test replay done");
		rst_pin(1'b1, 1'b1, 1'b1);
		chk("flags", 32'h13, flags_o);
		apb(1'b0, 8'h00, 32'h0);
		chk("method", 32'h300, rd & 32'h300);
		apb(1'b1, 8'h04, 32'h12);
		apb(1'b0, 8'h04, 32'h0);
		chk("empty ofs", 32'h3FF, rd[15:0]);
		ser_load({10'h123, 10'h045});
		apb(1'b0, 8'h04, 32'h0);
		chk("serial empty ofs", 32'h123, rd[15:0]);
		apb(1'b0, 8'h08, 32'h0);
		chk("serial full ofs", 32'h045, rd[15:0]);
		put(1, 0);
		chk("fall word", {23'h0, wd}, {23'h0, read_data_o});
		chk("ready_n", 32'h0, flags_o.empty_flag_n);
		exp_q.push_back(wd);
		u_dcf_far_end.rd(1);
		settle();
		chk("ready_n", 32'h1, flags_o.empty_flag_n);
		u_dcf_far_end.replay();
		settle();
		chk("ready_n", 32'h0, flags_o.empty_flag_n);
		chk("replay word", {23'h0, wd}, {23'h0, read_data_o});
		$display("test fall-through done");
		end_of_test();
	end
endmodule : dcf_fifo_ctrl_bench
`default_nettype wire
